// File: logic/dpr_consts.vh
// Purpose: Shared constants for the dual-port block memory.
// Assumes: Included by the memory top and its row store.
// Notes:   Storage unit is one data lane plus its extra bits.
//
// Functional notes
// - Each port's address width follows from its data width; wider ports get fewer bits.
// - Enabled edge with store strobe writes the port word at its location.
// - A port's configured width applies equally to its write and read paths.
// - Extra bits are stored and returned as plain data, never checked.
// - Extra bit count per word follows the port's total configured width.
// - Enabled edge without store strobe presents the stored word on the output.
// - New-data mode: a write also drives the freshly written word out.
// - Old-data mode: a write drives out the word held before overwriting.
// - Hold mode: output register keeps its value during write cycles.
// - Inactive port neither reads nor writes; memory and output stay unchanged.
// - Output preset loads the preset value into the output register instead.
// - Each port acts only on its own tick edge, independent of the other.
// - Ports may use different widths over one shared array of bits.
// - Same-address cross-port write: old mode shows old data, else output invalid; here a read on the other port returns old data in every mode.
`ifndef DPR_CONSTS_VH
`define DPR_CONSTS_VH

// ------------------------------------------------------------
// Storage unit
// ------------------------------------------------------------
`define DPR_UNIT_DATA   8
`define DPR_UNIT_EXTRA  1

// ------------------------------------------------------------
// Default geometry
// ------------------------------------------------------------
`define DPR_ROWS        512
`define DPR_A_LANES     4
`define DPR_B_LANES     2

// ------------------------------------------------------------
// Write modes
// ------------------------------------------------------------
`define DPR_MODE_NEW    2'h0
`define DPR_MODE_OLD    2'h1
`define DPR_MODE_HOLD   2'h2

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define DPR_PRESET_BIT  1'h0
`define DPR_TICK_RESET  3'h0

`endif

// File: logic/dpr_row_mem.v
// Purpose: Row-wide store with per-lane write masks and registered reads.
// Assumes: One clock; both access ports may act in the same cycle.
// Notes:   Read returns the row as it was before a same-cycle write.
`timescale 1ns/1ps
`include "dpr_consts.vh"

module dpr_row_mem #(
	parameter ROWS  = `DPR_ROWS,
	parameter LANES = `DPR_A_LANES,
	parameter UW    = `DPR_UNIT_DATA + `DPR_UNIT_EXTRA,
	parameter RWB   = 9
) (
	input  wire                  clk_sys,
	input  wire                  rstn,
	input  wire                  a_en,
	input  wire [LANES-1:0]      a_wmask,
	input  wire [RWB-1:0]        a_row,
	input  wire [LANES*UW-1:0]   a_wdata,
	output reg  [LANES*UW-1:0]   a_rdata,
	input  wire                  b_en,
	input  wire [LANES-1:0]      b_wmask,
	input  wire [RWB-1:0]        b_row,
	input  wire [LANES*UW-1:0]   b_wdata,
	output reg  [LANES*UW-1:0]   b_rdata
);

	reg [LANES*UW-1:0] mem [0:ROWS-1];
	integer            i;

	// ------------------------------------------------------------
	// Writes; port B is applied last on a same-lane collision
	// ------------------------------------------------------------
	always @(posedge clk_sys) begin
		for (i = 0; i < LANES; i = i + 1) begin
			if (a_en && a_wmask[i]) begin
				mem[a_row][i*UW +: UW] <= a_wdata[i*UW +: UW];
			end
			if (b_en && b_wmask[i]) begin
				mem[b_row][i*UW +: UW] <= b_wdata[i*UW +: UW];
			end
		end
	end

	// ------------------------------------------------------------
	// Registered reads see pre-write contents
	// ------------------------------------------------------------
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			a_rdata <= {LANES*UW{1'b0}};
			b_rdata <= {LANES*UW{1'b0}};
		end else begin
			if (a_en) begin
				a_rdata <= mem[a_row];
			end
			if (b_en) begin
				b_rdata <= mem[b_row];
			end
		end
	end

endmodule

// File: logic/dpr_dual_port_ram.v
// Purpose: Dual-port block memory with bus-matched widths and write modes.
// Assumes: Port ticks and controls arrive as pins; clk_sys is much faster than ticks.
// Notes:   Each port acts once per detected rising edge of its own tick.
`timescale 1ns/1ps
`include "dpr_consts.vh"

module dpr_dual_port_ram #(
	parameter       ROWS     = `DPR_ROWS,
	parameter       A_LANES  = `DPR_A_LANES,
	parameter       B_LANES  = `DPR_B_LANES,
	parameter [1:0] A_MODE   = `DPR_MODE_NEW,
	parameter [1:0] B_MODE   = `DPR_MODE_NEW,
	// Derived widths below up to the presets; leave those at their defaults
	parameter       UD       = `DPR_UNIT_DATA,
	parameter       UP       = `DPR_UNIT_EXTRA,
	parameter       RL       = (A_LANES > B_LANES) ? A_LANES : B_LANES,
	parameter       A_AW     = $clog2(ROWS * (RL / A_LANES)),
	parameter       B_AW     = $clog2(ROWS * (RL / B_LANES)),
	parameter       A_DW     = A_LANES * UD,
	parameter       B_DW     = B_LANES * UD,
	parameter       A_PW     = A_LANES * UP,
	parameter       B_PW     = B_LANES * UP,
	parameter [A_DW-1:0] A_PRESET_WORD  = {A_DW{`DPR_PRESET_BIT}},
	parameter [A_PW-1:0] A_PRESET_EXTRA = {A_PW{`DPR_PRESET_BIT}},
	parameter [B_DW-1:0] B_PRESET_WORD  = {B_DW{`DPR_PRESET_BIT}},
	parameter [B_PW-1:0] B_PRESET_EXTRA = {B_PW{`DPR_PRESET_BIT}}
) (
	input  wire            clk_sys,
	input  wire            rstn,
	input  wire            port_a_tick,
	input  wire            port_a_active,
	input  wire            port_a_store_strobe,
	input  wire            port_a_output_preset,
	input  wire [A_AW-1:0] port_a_location,
	input  wire [A_DW-1:0] port_a_write_word,
	input  wire [A_PW-1:0] port_a_write_extra_bits,
	output reg  [A_DW-1:0] port_a_read_word,
	output reg  [A_PW-1:0] port_a_read_extra_bits,
	input  wire            port_b_tick,
	input  wire            port_b_active,
	input  wire            port_b_store_strobe,
	input  wire            port_b_output_preset,
	input  wire [B_AW-1:0] port_b_location,
	input  wire [B_DW-1:0] port_b_write_word,
	input  wire [B_PW-1:0] port_b_write_extra_bits,
	output reg  [B_DW-1:0] port_b_read_word,
	output reg  [B_PW-1:0] port_b_read_extra_bits
);

	// ------------------------------------------------------------
	// Geometry
	// ------------------------------------------------------------
	localparam UW      = UD + UP;
	localparam RWB     = $clog2(ROWS);
	localparam ROW_W   = RL * UW;
	localparam A_SPLIT = RL / A_LANES;
	localparam B_SPLIT = RL / B_LANES;
	localparam LW      = $clog2(RL) + 1;
	localparam A_BW    = 3 + A_AW + A_PW + A_DW;
	localparam B_BW    = 3 + B_AW + B_PW + B_DW;

	// ------------------------------------------------------------
	// Pin synchronisers: tick edges and control bundles
	// ------------------------------------------------------------
	// Bundles travel beside the tick at equal depth, so values taken at
	// the detected edge are as old as the edge itself.
	reg  [2:0]      a_tk_q;
	reg  [2:0]      b_tk_q;
	reg             a_lvl_q;
	reg             b_lvl_q;
	reg  [A_BW-1:0] a_s1_q;
	reg  [A_BW-1:0] a_s2_q;
	reg  [A_BW-1:0] a_s3_q;
	reg  [B_BW-1:0] b_s1_q;
	reg  [B_BW-1:0] b_s2_q;
	reg  [B_BW-1:0] b_s3_q;
	wire [A_BW-1:0] a_raw;
	wire [B_BW-1:0] b_raw;

	assign a_raw = {port_a_active, port_a_store_strobe, port_a_output_preset,
		port_a_location, port_a_write_extra_bits, port_a_write_word};
	assign b_raw = {port_b_active, port_b_store_strobe, port_b_output_preset,
		port_b_location, port_b_write_extra_bits, port_b_write_word};

	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			a_tk_q  <= `DPR_TICK_RESET;
			b_tk_q  <= `DPR_TICK_RESET;
			a_lvl_q <= 1'b0;
			b_lvl_q <= 1'b0;
			a_s1_q  <= {A_BW{1'b0}};
			a_s2_q  <= {A_BW{1'b0}};
			a_s3_q  <= {A_BW{1'b0}};
			b_s1_q  <= {B_BW{1'b0}};
			b_s2_q  <= {B_BW{1'b0}};
			b_s3_q  <= {B_BW{1'b0}};
		end else begin
			a_tk_q <= {a_tk_q[1:0], port_a_tick};
			b_tk_q <= {b_tk_q[1:0], port_b_tick};
			a_s1_q <= a_raw;
			a_s2_q <= a_s1_q;
			a_s3_q <= a_s2_q;
			b_s1_q <= b_raw;
			b_s2_q <= b_s1_q;
			b_s3_q <= b_s2_q;
			if (a_tk_q[1] == a_tk_q[2]) begin
				a_lvl_q <= a_tk_q[2];
			end
			if (b_tk_q[1] == b_tk_q[2]) begin
				b_lvl_q <= b_tk_q[2];
			end
		end
	end

	// Each port is timed only by its own tick
	wire a_edge = (a_tk_q[1] == a_tk_q[2]) & a_tk_q[2] & ~a_lvl_q;
	wire b_edge = (b_tk_q[1] == b_tk_q[2]) & b_tk_q[2] & ~b_lvl_q;

	// ------------------------------------------------------------
	// Field split of the synchronised bundles
	// ------------------------------------------------------------
	wire            a_act  = a_s3_q[A_BW-1];
	wire            a_str  = a_s3_q[A_BW-2];
	wire            a_pre  = a_s3_q[A_BW-3];
	wire [A_AW-1:0] a_loc  = a_s3_q[A_PW+A_DW +: A_AW];
	wire [A_PW-1:0] a_xin  = a_s3_q[A_DW +: A_PW];
	wire [A_DW-1:0] a_win  = a_s3_q[A_DW-1:0];
	wire            b_act  = b_s3_q[B_BW-1];
	wire            b_str  = b_s3_q[B_BW-2];
	wire            b_pre  = b_s3_q[B_BW-3];
	wire [B_AW-1:0] b_loc  = b_s3_q[B_PW+B_DW +: B_AW];
	wire [B_PW-1:0] b_xin  = b_s3_q[B_DW +: B_PW];
	wire [B_DW-1:0] b_win  = b_s3_q[B_DW-1:0];

	// Inactive ports touch neither memory nor output
	wire a_go = a_edge & a_act;
	wire b_go = b_edge & b_act;

	// ------------------------------------------------------------
	// Address decode and lane packing
	// ------------------------------------------------------------
	reg  [RWB-1:0]     a_row;
	reg  [RWB-1:0]     b_row;
	reg  [LW-1:0]      a_base;
	reg  [LW-1:0]      b_base;
	reg  [RL-1:0]      a_mask;
	reg  [RL-1:0]      b_mask;
	reg  [A_LANES*UW-1:0] a_pack;
	reg  [B_LANES*UW-1:0] b_pack;
	integer            ia;
	integer            ib;
	integer            a_off;
	integer            b_off;

	always @* begin
		// Low location bits pick the lane group; wider ports lose them
		a_row = a_loc[A_AW-1 -: RWB];
		a_off = a_loc % A_SPLIT;
		a_base = a_off[LW-1:0] * A_LANES[LW-1:0];
		a_mask = {RL{1'b0}};
		a_pack = {A_LANES*UW{1'b0}};
		for (ia = 0; ia < RL; ia = ia + 1) begin
			a_mask[ia] = a_str && ((ia / A_LANES) == a_off);
		end
		for (ia = 0; ia < A_LANES; ia = ia + 1) begin
			// Extra bits ride in the lane as ordinary bits
			a_pack[ia*UW +: UW] = {a_xin[ia*UP +: UP], a_win[ia*UD +: UD]};
		end
	end

	always @* begin
		b_row = b_loc[B_AW-1 -: RWB];
		b_off = b_loc % B_SPLIT;
		b_base = b_off[LW-1:0] * B_LANES[LW-1:0];
		b_mask = {RL{1'b0}};
		b_pack = {B_LANES*UW{1'b0}};
		for (ib = 0; ib < RL; ib = ib + 1) begin
			b_mask[ib] = b_str && ((ib / B_LANES) == b_off);
		end
		for (ib = 0; ib < B_LANES; ib = ib + 1) begin
			b_pack[ib*UW +: UW] = {b_xin[ib*UP +: UP], b_win[ib*UD +: UD]};
		end
	end

	// ------------------------------------------------------------
	// Shared array
	// ------------------------------------------------------------
	wire [ROW_W-1:0] a_rrow;
	wire [ROW_W-1:0] b_rrow;

	dpr_row_mem #(
		.ROWS  (ROWS),
		.LANES (RL),
		.UW    (UW),
		.RWB   (RWB)
	) u_mem (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.a_en    (a_go),
		.a_wmask (a_mask),
		.a_row   (a_row),
		.a_wdata ({A_SPLIT{a_pack}}),
		.a_rdata (a_rrow),
		.b_en    (b_go),
		.b_wmask (b_mask),
		.b_row   (b_row),
		.b_wdata ({B_SPLIT{b_pack}}),
		.b_rdata (b_rrow)
	);

	// ------------------------------------------------------------
	// Access pipeline: one cycle to read the row
	// ------------------------------------------------------------
	reg             a_pend_q;
	reg             a_pwr_q;
	reg             a_ppre_q;
	reg  [LW-1:0]   a_pbase_q;
	reg  [A_DW-1:0] a_pword_q;
	reg  [A_PW-1:0] a_pxtra_q;
	reg             b_pend_q;
	reg             b_pwr_q;
	reg             b_ppre_q;
	reg  [LW-1:0]   b_pbase_q;
	reg  [B_DW-1:0] b_pword_q;
	reg  [B_PW-1:0] b_pxtra_q;

	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			a_pend_q  <= 1'b0;
			a_pwr_q   <= 1'b0;
			a_ppre_q  <= 1'b0;
			a_pbase_q <= {LW{1'b0}};
			a_pword_q <= {A_DW{1'b0}};
			a_pxtra_q <= {A_PW{1'b0}};
			b_pend_q  <= 1'b0;
			b_pwr_q   <= 1'b0;
			b_ppre_q  <= 1'b0;
			b_pbase_q <= {LW{1'b0}};
			b_pword_q <= {B_DW{1'b0}};
			b_pxtra_q <= {B_PW{1'b0}};
		end else begin
			a_pend_q <= a_go;
			b_pend_q <= b_go;
			if (a_go) begin
				a_pwr_q   <= a_str;
				a_ppre_q  <= a_pre;
				a_pbase_q <= a_base;
				a_pword_q <= a_win;
				a_pxtra_q <= a_xin;
			end
			if (b_go) begin
				b_pwr_q   <= b_str;
				b_ppre_q  <= b_pre;
				b_pbase_q <= b_base;
				b_pword_q <= b_win;
				b_pxtra_q <= b_xin;
			end
		end
	end

	// ------------------------------------------------------------
	// Lane extraction from the read row
	// ------------------------------------------------------------
	reg  [A_DW-1:0] a_mword;
	reg  [A_PW-1:0] a_mxtra;
	reg  [B_DW-1:0] b_mword;
	reg  [B_PW-1:0] b_mxtra;
	reg  [UW-1:0]   a_unit;
	reg  [UW-1:0]   b_unit;
	integer         ja;
	integer         jb;

	always @* begin
		a_mword = {A_DW{1'b0}};
		a_mxtra = {A_PW{1'b0}};
		a_unit = {UW{1'b0}};
		for (ja = 0; ja < A_LANES; ja = ja + 1) begin
			a_unit = a_rrow[(a_pbase_q + ja) * UW +: UW];
			a_mword[ja*UD +: UD] = a_unit[UD-1:0];
			a_mxtra[ja*UP +: UP] = a_unit[UW-1:UD];
		end
	end

	always @* begin
		b_mword = {B_DW{1'b0}};
		b_mxtra = {B_PW{1'b0}};
		b_unit = {UW{1'b0}};
		for (jb = 0; jb < B_LANES; jb = jb + 1) begin
			b_unit = b_rrow[(b_pbase_q + jb) * UW +: UW];
			b_mword[jb*UD +: UD] = b_unit[UD-1:0];
			b_mxtra[jb*UP +: UP] = b_unit[UW-1:UD];
		end
	end

	// ------------------------------------------------------------
	// Output registers
	// ------------------------------------------------------------
	// Preset outranks every write mode; the write itself still lands.
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			port_a_read_word       <= A_PRESET_WORD;
			port_a_read_extra_bits <= A_PRESET_EXTRA;
		end else if (a_pend_q) begin
			if (a_ppre_q) begin
				port_a_read_word       <= A_PRESET_WORD;
				port_a_read_extra_bits <= A_PRESET_EXTRA;
			end else if (!a_pwr_q) begin
				port_a_read_word       <= a_mword;
				port_a_read_extra_bits <= a_mxtra;
			end else if (A_MODE == `DPR_MODE_NEW) begin
				port_a_read_word       <= a_pword_q;
				port_a_read_extra_bits <= a_pxtra_q;
			end else if (A_MODE == `DPR_MODE_OLD) begin
				port_a_read_word       <= a_mword;
				port_a_read_extra_bits <= a_mxtra;
			end
			// Hold mode leaves the register untouched on writes
		end
	end

	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			port_b_read_word       <= B_PRESET_WORD;
			port_b_read_extra_bits <= B_PRESET_EXTRA;
		end else if (b_pend_q) begin
			if (b_ppre_q) begin
				port_b_read_word       <= B_PRESET_WORD;
				port_b_read_extra_bits <= B_PRESET_EXTRA;
			end else if (!b_pwr_q) begin
				port_b_read_word       <= b_mword;
				port_b_read_extra_bits <= b_mxtra;
			end else if (B_MODE == `DPR_MODE_NEW) begin
				port_b_read_word       <= b_pword_q;
				port_b_read_extra_bits <= b_pxtra_q;
			end else if (B_MODE == `DPR_MODE_OLD) begin
				port_b_read_word       <= b_mword;
				port_b_read_extra_bits <= b_mxtra;
			end
			// Hold mode leaves the register untouched on writes
		end
	end

endmodule

// File: tb/dpr_ram_monitor.sv
// Purpose: Port-level timing and mode checks for the dual-port memory.
// Assumes: Outputs update five clk_sys edges after a tick rise.
// Notes:   Contents are not modelled here; the bench compares data.
`timescale 1ns/1ps
`include "dpr_consts.vh"

module dpr_ram_monitor #(
	parameter            A_DW           = 32,
	parameter            A_PW           = 4,
	parameter            B_DW           = 16,
	parameter            B_PW           = 2,
	parameter [1:0]      A_MODE         = 2'h0,
	parameter [1:0]      B_MODE         = 2'h0,
	parameter [A_DW-1:0] A_PRESET_WORD  = '0,
	parameter [A_PW-1:0] A_PRESET_EXTRA = '0,
	parameter [B_DW-1:0] B_PRESET_WORD  = '0,
	parameter [B_PW-1:0] B_PRESET_EXTRA = '0
) (
	input wire            clk_sys,
	input wire            rstn,
	input wire            port_a_tick,
	input wire            port_a_active,
	input wire            port_a_store_strobe,
	input wire            port_a_output_preset,
	input wire [A_DW-1:0] port_a_write_word,
	input wire [A_PW-1:0] port_a_write_extra_bits,
	input wire [A_DW-1:0] port_a_read_word,
	input wire [A_PW-1:0] port_a_read_extra_bits,
	input wire            port_b_tick,
	input wire            port_b_active,
	input wire            port_b_store_strobe,
	input wire            port_b_output_preset,
	input wire [B_DW-1:0] port_b_write_word,
	input wire [B_PW-1:0] port_b_write_extra_bits,
	input wire [B_DW-1:0] port_b_read_word,
	input wire [B_PW-1:0] port_b_read_extra_bits
);
	wire [A_DW+A_PW-1:0] a_out = {port_a_read_extra_bits, port_a_read_word};
	wire [A_DW+A_PW-1:0] a_in  = {port_a_write_extra_bits, port_a_write_word};
	wire [B_DW+B_PW-1:0] b_out = {port_b_read_extra_bits, port_b_read_word};
	wire [B_DW+B_PW-1:0] b_in  = {port_b_write_extra_bits, port_b_write_word};

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	property p_quiet_a;
		$changed(a_out) |-> $past(port_a_tick, 5) && !$past(port_a_tick, 6);
	endproperty
	a_quiet_a: assert property (p_quiet_a) else $error("port A output moved off schedule");
	property p_quiet_b;
		$changed(b_out) |-> $past(port_b_tick, 5) && !$past(port_b_tick, 6);
	endproperty
	a_quiet_b: assert property (p_quiet_b) else $error("port B output moved off schedule");
	property p_idle_a;
		$rose(port_a_tick) && !port_a_active |-> ##5 $stable(a_out);
	endproperty
	a_idle_a: assert property (p_idle_a) else $error("inactive port A output changed");
	property p_preset_a;
		$rose(port_a_tick) && port_a_active && port_a_output_preset
			|-> ##5 a_out == {A_PRESET_EXTRA, A_PRESET_WORD};
	endproperty
	a_preset_a: assert property (p_preset_a) else $error("port A preset not loaded");
	property p_preset_b;
		$rose(port_b_tick) && port_b_active && port_b_output_preset
			|-> ##5 b_out == {B_PRESET_EXTRA, B_PRESET_WORD};
	endproperty
	a_preset_b: assert property (p_preset_b) else $error("port B preset not loaded");
	property p_new_a;
		$rose(port_a_tick) && port_a_active && port_a_store_strobe && !port_a_output_preset
			&& A_MODE == `DPR_MODE_NEW |-> ##5 a_out == $past(a_in, 5);
	endproperty
	a_new_a: assert property (p_new_a) else $error("port A new word not shown");
	property p_new_b;
		$rose(port_b_tick) && port_b_active && port_b_store_strobe && !port_b_output_preset
			&& B_MODE == `DPR_MODE_NEW |-> ##5 b_out == $past(b_in, 5);
	endproperty
	a_new_b: assert property (p_new_b) else $error("port B new word not shown");
	property p_hold_b;
		$rose(port_b_tick) && port_b_active && port_b_store_strobe && !port_b_output_preset
			&& B_MODE == `DPR_MODE_HOLD |-> ##5 $stable(b_out);
	endproperty
	a_hold_b: assert property (p_hold_b) else $error("port B output moved in hold");
	property p_reset;
		$rose(rstn) |-> a_out == {A_PRESET_EXTRA, A_PRESET_WORD}
			&& b_out == {B_PRESET_EXTRA, B_PRESET_WORD};
	endproperty
	a_reset: assert property (p_reset) else $error("output not preset after reset");
endmodule

bind dpr_dual_port_ram dpr_ram_monitor #(
	.A_DW(A_DW), .A_PW(A_PW), .B_DW(B_DW), .B_PW(B_PW), .A_MODE(A_MODE), .B_MODE(B_MODE),
	.A_PRESET_WORD(A_PRESET_WORD), .A_PRESET_EXTRA(A_PRESET_EXTRA),
	.B_PRESET_WORD(B_PRESET_WORD), .B_PRESET_EXTRA(B_PRESET_EXTRA)
) u_mon (
	.clk_sys(clk_sys), .rstn(rstn), .port_a_tick(port_a_tick),
	.port_a_active(port_a_active), .port_a_store_strobe(port_a_store_strobe),
	.port_a_output_preset(port_a_output_preset), .port_a_write_word(port_a_write_word),
	.port_a_write_extra_bits(port_a_write_extra_bits), .port_a_read_word(port_a_read_word),
	.port_a_read_extra_bits(port_a_read_extra_bits), .port_b_tick(port_b_tick),
	.port_b_active(port_b_active), .port_b_store_strobe(port_b_store_strobe),
	.port_b_output_preset(port_b_output_preset), .port_b_write_word(port_b_write_word),
	.port_b_write_extra_bits(port_b_write_extra_bits), .port_b_read_word(port_b_read_word),
	.port_b_read_extra_bits(port_b_read_extra_bits)
);

// File: tb/dpr_port_user.sv
// Purpose: User logic model driving one memory port.
// Assumes: Tick high four clk_sys cycles, low at least six.
// Notes:   Released pins are inverted so a stale value never passes.
`timescale 1ns/1ps

module dpr_port_user #(
	parameter AW = 9,
	parameter DW = 32,
	parameter PW = 4
) (
	input  wire          clk_sys,
	output reg           tick,
	output reg           active,
	output reg           store,
	output reg           preset,
	output reg  [AW-1:0] loc,
	output reg  [DW-1:0] word,
	output reg  [PW-1:0] extra
);
	initial begin
		tick = 1'b0;
		active = 1'b0;
		store = 1'b0;
		preset = 1'b0;
		loc = '0;
		{extra, word} = '0;
	end

	// ----
	// One access per tick rise
	// ----
	task automatic acc(input logic a, s, r, input logic [AW-1:0] l,
		input logic [DW+PW-1:0] d);
		@(posedge clk_sys);
		active <= a;
		store <= s;
		preset <= r;
		loc <= l;
		{extra, word} <= d;
		@(posedge clk_sys);
		tick <= 1'b1;
		repeat (4) @(posedge clk_sys);
		tick <= 1'b0;
		// Pins held well past the five-edge input pipeline
		repeat (4) @(posedge clk_sys);
		active <= 1'b0;
		loc <= ~l;
		{extra, word} <= ~d;
	endtask
endmodule

// File: tb/tb_dual_port_block_ram.sv
// Purpose: Self-checking bench for the dual-port memory.
// Assumes: DUT runs old/hold modes, DUT2 new/new, same pins.
// Notes:   Old-mode reads of unwritten rows are not compared.
`timescale 1ns/1ps
`include "dpr_consts.vh"

module tb_dual_port_block_ram;
	typedef struct packed {
		logic [4:0]  ctl;
		logic [9:0]  loc;
		logic [35:0] w;
		logic [35:0] e1;
		logic [35:0] e2;
	} dpr_row_t;
	localparam logic [35:0] A_PRE = 36'h95A5AC3C3;
	localparam logic [35:0] B_PRE = 36'h000023C96;
	logic        clk_sys = 1'b0;
	logic        rstn = 1'b0;
	int          errors = 0;
	int          num_checks = 0;
	int          cycle_q = 0;
	wire         port_a_tick, port_a_active, port_a_store_strobe, port_a_output_preset;
	wire         port_b_tick, port_b_active, port_b_store_strobe, port_b_output_preset;
	wire [8:0]   port_a_location;
	wire [9:0]   port_b_location;
	wire [31:0]  port_a_write_word, port_a_read_word, n_a_word;
	wire [3:0]   port_a_write_extra_bits, port_a_read_extra_bits, n_a_extra;
	wire [15:0]  port_b_write_word, port_b_read_word, n_b_word;
	wire [1:0]   port_b_write_extra_bits, port_b_read_extra_bits, n_b_extra;
	wire [35:0]  o1a = {port_a_read_extra_bits, port_a_read_word};
	wire [35:0]  o1b = {18'h0, port_b_read_extra_bits, port_b_read_word};
	wire [35:0]  o2a = {n_a_extra, n_a_word};
	wire [35:0]  o2b = {18'h0, n_b_extra, n_b_word};
	// Control bits: port B, active, store, preset, compare DUT
	dpr_row_t    rows [0:12] = '{
		'{5'h0C, 10'h005, 36'hA11223344, 36'h0, 36'hA11223344},
		'{5'h0D, 10'h005, 36'h555667788, 36'hA11223344, 36'h555667788},
		'{5'h09, 10'h005, 36'h0, 36'h555667788, 36'h555667788},
		'{5'h0C, 10'h1FF, 36'hFDEADBEEF, 36'h0, 36'hFDEADBEEF},
		'{5'h19, 10'h3FF, 36'h0, 36'h00003DEAD, 36'h00003DEAD},
		'{5'h19, 10'h00B, 36'h0, 36'h000015566, 36'h000015566},
		'{5'h1D, 10'h00A, 36'h00002CAFE, 36'h000015566, 36'h00002CAFE},
		'{5'h09, 10'h005, 36'h0, 36'h65566CAFE, 36'h65566CAFE},
		'{5'h05, 10'h005, 36'h012345678, 36'h65566CAFE, 36'h65566CAFE},
		'{5'h09, 10'h005, 36'h0, 36'h65566CAFE, 36'h65566CAFE},
		'{5'h0F, 10'h005, 36'h30BADF00D, A_PRE, A_PRE},
		'{5'h09, 10'h005, 36'h0, 36'h30BADF00D, 36'h30BADF00D},
		'{5'h1B, 10'h00A, 36'h0, B_PRE, B_PRE}
	};

	always #12.5 clk_sys = ~clk_sys;

	dpr_dual_port_ram #(.A_MODE(`DPR_MODE_OLD), .B_MODE(`DPR_MODE_HOLD),
		.A_PRESET_WORD(A_PRE[31:0]), .A_PRESET_EXTRA(A_PRE[35:32]),
		.B_PRESET_WORD(B_PRE[15:0]), .B_PRESET_EXTRA(B_PRE[17:16])) DUT (.*);
	// Second copy keeps both write modes at their new-data default
	dpr_dual_port_ram #(
		.A_PRESET_WORD(A_PRE[31:0]), .A_PRESET_EXTRA(A_PRE[35:32]),
		.B_PRESET_WORD(B_PRE[15:0]), .B_PRESET_EXTRA(B_PRE[17:16])) DUT2 (.*,
		.port_a_read_word(n_a_word), .port_a_read_extra_bits(n_a_extra),
		.port_b_read_word(n_b_word), .port_b_read_extra_bits(n_b_extra));
	dpr_port_user pa (.clk_sys(clk_sys), .tick(port_a_tick),
		.active(port_a_active), .store(port_a_store_strobe), .preset(port_a_output_preset),
		.loc(port_a_location), .word(port_a_write_word), .extra(port_a_write_extra_bits));
	dpr_port_user #(.AW(10), .DW(16), .PW(2)) pb (.clk_sys(clk_sys), .tick(port_b_tick),
		.active(port_b_active), .store(port_b_store_strobe), .preset(port_b_output_preset),
		.loc(port_b_location), .word(port_b_write_word), .extra(port_b_write_extra_bits));

	task chk(input logic [35:0] seen, input logic [35:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task summarize;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Hang guard; a full run needs about 160 cycles
	always @(posedge clk_sys) begin
		cycle_q <= cycle_q + 1;
		if (cycle_q == 600) begin
			errors++;
			summarize();
		end
	end

	initial begin
		int i;
		dpr_row_t r;
		repeat (8) @(posedge clk_sys);
		rstn <= 1'b1;
		@(posedge clk_sys);
		chk(o1a, A_PRE);
		chk(o1b, B_PRE);
		$display("reset values done");
		for (i = 0; i < 13; i++) begin
			r = rows[i];
			if (r.ctl[4]) begin
				pb.acc(r.ctl[3], r.ctl[2], r.ctl[1], r.loc, r.w[17:0]);
			end else begin
				pa.acc(r.ctl[3], r.ctl[2], r.ctl[1], r.loc[8:0], r.w);
			end
			if (r.ctl[0]) chk(r.ctl[4] ? o1b : o1a, r.e1);
			chk(r.ctl[4] ? o2b : o2a, r.e2);
			$display("row %0d done", i);
		end
		// Same-cycle write on A and read on B of one row
		fork
			pa.acc(1'b1, 1'b1, 1'b0, 9'h005, 36'h7CCCCDDDD);
			pb.acc(1'b1, 1'b0, 1'b0, 10'h00A, 18'h0);
		join
		chk(o1b, 36'h00003F00D);
		chk(o1a, 36'h30BADF00D);
		chk(o2a, 36'h7CCCCDDDD);
		$display("collision done");
		rstn <= 1'b0;
		repeat (2) @(posedge clk_sys);
		chk(o1a, A_PRE);
		chk(o2b, B_PRE);
		rstn <= 1'b1;
		repeat (2) @(posedge clk_sys);
		// Reset presets outputs only; the array keeps the collision write
		pa.acc(1'b1, 1'b0, 1'b0, 9'h005, 36'h0);
		chk(o1a, 36'h7CCCCDDDD);
		chk(o2a, 36'h7CCCCDDDD);
		$display("mid-run reset done");
		summarize();
	end
endmodule
